// *** core/sarsq_top.v ***
// successive-approximation converter sequencer: registers, triggers, mux, result buffer
`include "sarsq_map.vh"
module sarsq_top #(
	parameter CH_N = 16
) (
	input  wire            core_clk,
	input  wire            rst,
	input  wire            ce,
	input  wire [4:0]      reg_addr,
	input  wire [15:0]     reg_wdata,
	input  wire            reg_wr,
	input  wire            reg_rd,
	output reg  [15:0]     reg_rdata,
	input  wire            device_idle,
	input  wire            rc_tick,
	input  wire            timer3_event,
	input  wire            timer5_event,
	input  wire            charge_time_unit_event,
	input  wire            external_irq_zero,
	input  wire            conv_done,
	input  wire [9:0]      conv_code,
	output reg             converter_irq_flag,
	output reg             sample_enable,
	output reg             conv_start,
	output reg  [4:0]      positive_select,
	output reg             negative_alt,
	output reg  [2:0]      reference_select,
	output reg  [CH_N-1:0] pin_analog_config,
	output reg             conv_clk_tick
);
	localparam ST_OFF  = 2'h0;
	localparam ST_IDLE = 2'h1;
	localparam ST_SAMPLE_BIT = 2'h2;
	localparam ST_CONV = 2'h3;

	reg [15:0] con1_reg;
	reg [15:0] con2_reg;
	reg [15:0] con3_reg;
	reg [15:0] chsel_reg;
	reg [15:0] pincfg_reg;
	reg [15:0] scansel_reg;
	reg [1:0]  state_reg;
	reg [4:0]  sample_bit_cnt_reg;
	reg [3:0]  seq_cnt_reg;
	reg [3:0]  wptr_reg;
	reg        half_reg;
	reg        alt_b_reg;
	reg [3:0]  scan_ch_reg;
	reg        ext_s1_reg;
	reg        ext_s2_reg;
	reg        ext_s3_reg;
	reg        ev_s1_reg;
	reg        ev_s2_reg;
	reg        ev_s3_reg;
	reg [15:0] buffer_mem [0:15];
	wire       tick;
	wire [15:0] fmt_word;
	wire       running;
	wire       trig_hit;
	wire       sw_sample_bit_clear;
	wire       sw_sample_bit_set;
	wire [3:0] next_scan;
	wire [3:0] wr_index;
	wire [2:0] trig;
	integer    i;

	function [3:0] scan_next;
		input [3:0]  cur;
		input [15:0] mask;
		integer k;
		reg found;
		reg [3:0] idx;
		begin
			scan_next = cur;
			found = 1'b0;
			idx = cur;
			for (k = 1; k <= 16; k = k + 1)
			begin
				idx = cur + k[3:0];
				if (!found && mask[idx])
				begin
					scan_next = idx;
					found = 1'b1;
				end
			end
		end
	endfunction

	function [15:0] reg_mask;
		input [4:0] addr;
		begin
			case (addr[3:0])
				`SARSQ_ADDR_CON1:  reg_mask = `SARSQ_CON1_MASK;
				`SARSQ_ADDR_CON2:  reg_mask = `SARSQ_CON2_MASK;
				`SARSQ_ADDR_CON3:  reg_mask = `SARSQ_CON3_MASK;
				`SARSQ_ADDR_CHSEL: reg_mask = `SARSQ_CHSEL_MASK;
				default:           reg_mask = 16'hFFFF;
			endcase
		end
	endfunction

	assign trig = con1_reg[7:5];
	assign running = con1_reg[`SARSQ_BIT_ON] && !(con1_reg[`SARSQ_BIT_IDLE] && device_idle);
	assign next_scan = scan_next(scan_ch_reg, scansel_reg);
	assign wr_index = (con2_reg[`SARSQ_BIT_BUFFER_SPLIT_MODE] ? {half_reg, wptr_reg[2:0]} : wptr_reg);
	assign sw_sample_bit_clear = reg_wr && reg_addr == {1'b0, `SARSQ_ADDR_CON1} && !reg_wdata[`SARSQ_BIT_SAMPLE_BIT];
	assign sw_sample_bit_set = reg_wr && reg_addr == {1'b0, `SARSQ_ADDR_CON1} && reg_wdata[`SARSQ_BIT_SAMPLE_BIT];
	assign trig_hit =
		(trig == `SARSQ_TRIG_AUTO && tick && sample_bit_cnt_reg >= con3_reg[12:8]) ||
		(trig == `SARSQ_TRIG_CHARGE && ev_s2_reg && !ev_s3_reg) ||
		(trig == `SARSQ_TRIG_TMR3 && timer3_event) ||
		(trig == `SARSQ_TRIG_TMR5 && timer5_event) ||
		(trig == `SARSQ_TRIG_EXT && ext_s2_reg && !ext_s3_reg) ||
		(trig == `SARSQ_TRIG_MANUAL && sw_sample_bit_clear);

	sarsq_tick #(
		.DIV_W (8)
	) u_tick (
		.core_clk  (core_clk),
		.rst       (rst),
		.ce        (ce),
		.run       (running),
		.rc_select (con3_reg[`SARSQ_BIT_RC]),
		.rc_tick   (rc_tick),
		.divider   (con3_reg[7:0]),
		.tick      (tick)
	);

	sarsq_format u_format (
		.format (con1_reg[9:8]),
		.code   (conv_code),
		.word   (fmt_word)
	);

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			con1_reg <= 16'h0000;
			con2_reg <= 16'h0000;
			con3_reg <= 16'h0000;
			chsel_reg <= 16'h0000;
			pincfg_reg <= 16'h0000;
			scansel_reg <= 16'h0000;
			state_reg <= ST_OFF;
			sample_bit_cnt_reg <= 5'h00;
			seq_cnt_reg <= 4'h0;
			wptr_reg <= 4'h0;
			half_reg <= 1'b0;
			alt_b_reg <= 1'b0;
			scan_ch_reg <= 4'h0;
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_s3_reg <= 1'b0;
			ev_s1_reg <= 1'b0;
			ev_s2_reg <= 1'b0;
			ev_s3_reg <= 1'b0;
			reg_rdata <= 16'h0000;
			converter_irq_flag <= 1'b0;
			sample_enable <= 1'b0;
			conv_start <= 1'b0;
			positive_select <= 5'h00;
			negative_alt <= 1'b0;
			reference_select <= 3'h0;
			pin_analog_config <= {CH_N{1'b0}};
			conv_clk_tick <= 1'b0;
			for (i = 0; i < 16; i = i + 1)
				buffer_mem[i] <= 16'h0000;
		end
		else if (ce)
		begin
			ext_s1_reg <= external_irq_zero;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
			ev_s1_reg <= charge_time_unit_event;
			ev_s2_reg <= ev_s1_reg;
			ev_s3_reg <= ev_s2_reg;
			conv_start <= 1'b0;
			converter_irq_flag <= 1'b0;
			conv_clk_tick <= tick;
			reg_rdata <= 16'h0000;
			if (reg_rd)
			begin
				if (reg_addr[4] == `SARSQ_ADDR_BUFBASE)
					reg_rdata <= buffer_mem[reg_addr[3:0]];
				else
				begin
					case (reg_addr[3:0])
						`SARSQ_ADDR_CON1:    reg_rdata <= con1_reg;
						`SARSQ_ADDR_CON2:    reg_rdata <= con2_reg;
						`SARSQ_ADDR_CON3:    reg_rdata <= con3_reg;
						`SARSQ_ADDR_CHSEL:   reg_rdata <= chsel_reg;
						`SARSQ_ADDR_PINCFG:  reg_rdata <= pincfg_reg;
						`SARSQ_ADDR_SCANSEL: reg_rdata <= scansel_reg;
						`SARSQ_ADDR_STATUS:  reg_rdata <= {12'h000, scan_ch_reg};
						default:             reg_rdata <= 16'h0000;
					endcase
				end
			end
			if (reg_wr && !reg_addr[4])
			begin
				case (reg_addr[3:0])
					`SARSQ_ADDR_CON1:
						con1_reg <= (reg_wdata & `SARSQ_CON1_MASK & 16'hFFFE) |
							(con1_reg & 16'h0001);
					`SARSQ_ADDR_CON2:
						con2_reg <= (reg_wdata & reg_mask(reg_addr) & 16'hFF7F) |
							(con2_reg & 16'h0080);
					`SARSQ_ADDR_CON3:    con3_reg <= reg_wdata & reg_mask(reg_addr);
					`SARSQ_ADDR_CHSEL:   chsel_reg <= reg_wdata & reg_mask(reg_addr);
					`SARSQ_ADDR_PINCFG:  pincfg_reg <= reg_wdata;
					`SARSQ_ADDR_SCANSEL: scansel_reg <= reg_wdata;
					default:             ;
				endcase
			end
			pin_analog_config <= pincfg_reg[CH_N-1:0];
			case (con2_reg[15:13])
				`SARSQ_REF_EXTP: reference_select <= `SARSQ_REF_EXTP;
				`SARSQ_REF_EXTN: reference_select <= `SARSQ_REF_EXTN;
				`SARSQ_REF_BOTH: reference_select <= `SARSQ_REF_BOTH;
				default:         reference_select <= 3'h0;
			endcase
			if (alt_b_reg && con2_reg[`SARSQ_BIT_ALTERNATE_INPUT])
			begin
				positive_select <= chsel_reg[12:8];
				negative_alt <= 1'b1;
			end
			else
			begin
				positive_select <= con2_reg[`SARSQ_BIT_SCAN] ? {1'b0, scan_ch_reg} : chsel_reg[4:0];
				negative_alt <= 1'b0;
			end
			if (!con1_reg[`SARSQ_BIT_ON])
			begin
				state_reg <= ST_OFF;
				sample_enable <= 1'b0;
				con1_reg[`SARSQ_BIT_SAMPLE_BIT] <= sw_sample_bit_set && reg_wdata[`SARSQ_BIT_ON];
				seq_cnt_reg <= 4'h0;
				wptr_reg <= 4'h0;
				half_reg <= 1'b0;
				alt_b_reg <= 1'b0;
				con2_reg[`SARSQ_BIT_FILL_HALF_STATUS] <= 1'b0;
				for (i = 0; i < 16; i = i + 1)
					buffer_mem[i] <= 16'h0000;
			end
			else if (!running)
			begin
				state_reg <= ST_IDLE;
				sample_enable <= 1'b0;
				con1_reg[`SARSQ_BIT_SAMPLE_BIT] <= 1'b0;
			end
			else
			begin
				case (state_reg)
					ST_OFF:
						state_reg <= ST_IDLE;
					ST_IDLE:
						if (con1_reg[`SARSQ_BIT_AUTO_SAMPLE_START] || con1_reg[`SARSQ_BIT_SAMPLE_BIT] || sw_sample_bit_set)
						begin
							state_reg <= ST_SAMPLE_BIT;
							sample_enable <= 1'b1;
							sample_bit_cnt_reg <= 5'h00;
							con1_reg[`SARSQ_BIT_SAMPLE_BIT] <= 1'b1;
							con1_reg[`SARSQ_BIT_DONE] <= 1'b0;
						end
					ST_SAMPLE_BIT:
					begin
						if (tick && sample_bit_cnt_reg != 5'h1F)
							sample_bit_cnt_reg <= sample_bit_cnt_reg + 5'h01;
						if (trig_hit)
						begin
							state_reg <= ST_CONV;
							sample_enable <= 1'b0;
							conv_start <= 1'b1;
							con1_reg[`SARSQ_BIT_SAMPLE_BIT] <= 1'b0;
						end
					end
					ST_CONV:
						if (conv_done)
						begin
							buffer_mem[wr_index] <= fmt_word;
							con1_reg[`SARSQ_BIT_DONE] <= 1'b1;
							alt_b_reg <= ~alt_b_reg;
							if (con2_reg[`SARSQ_BIT_SCAN] && !(alt_b_reg && con2_reg[`SARSQ_BIT_ALTERNATE_INPUT]))
								scan_ch_reg <= next_scan;
							if (seq_cnt_reg >= con2_reg[5:2])
							begin
								seq_cnt_reg <= 4'h0;
								converter_irq_flag <= 1'b1;
								wptr_reg <= 4'h0;
								alt_b_reg <= 1'b0;
								if (con2_reg[`SARSQ_BIT_BUFFER_SPLIT_MODE])
								begin
									half_reg <= ~half_reg;
									con2_reg[`SARSQ_BIT_FILL_HALF_STATUS] <= ~half_reg;
								end
							end
							else
							begin
								seq_cnt_reg <= seq_cnt_reg + 4'h1;
								wptr_reg <= wptr_reg + 4'h1;
							end
							if (con1_reg[`SARSQ_BIT_AUTO_SAMPLE_START])
							begin
								state_reg <= ST_SAMPLE_BIT;
								sample_enable <= 1'b1;
								sample_bit_cnt_reg <= 5'h00;
								con1_reg[`SARSQ_BIT_SAMPLE_BIT] <= 1'b1;
							end
							else
								state_reg <= ST_IDLE;
						end
					default:
						state_reg <= ST_OFF;
				endcase
			end
		end
	end
endmodule

// *** core/sarsq_map.vh ***
// register map, field positions and encodings of the converter sequencer
`ifndef SARSQ_MAP_VH
`define SARSQ_MAP_VH
`define SARSQ_ADDR_CON1     4'h0
`define SARSQ_ADDR_CON2     4'h1
`define SARSQ_ADDR_CON3     4'h2
`define SARSQ_ADDR_CHSEL    4'h3
`define SARSQ_ADDR_PINCFG   4'h4
`define SARSQ_ADDR_SCANSEL  4'h5
`define SARSQ_ADDR_STATUS   4'h6
`define SARSQ_ADDR_BUFBASE  1'b1
`define SARSQ_CON1_MASK     16'hA3E7
`define SARSQ_CON2_MASK     16'hE43F
`define SARSQ_CON3_MASK     16'h9FFF
`define SARSQ_CHSEL_MASK    16'h1F1F
`define SARSQ_BIT_ON        15
`define SARSQ_BIT_IDLE      13
`define SARSQ_BIT_AUTO_SAMPLE_START      2
`define SARSQ_BIT_SAMPLE_BIT      1
`define SARSQ_BIT_DONE      0
`define SARSQ_BIT_SCAN      10
`define SARSQ_BIT_FILL_HALF_STATUS      7
`define SARSQ_BIT_BUFFER_SPLIT_MODE      1
`define SARSQ_BIT_ALTERNATE_INPUT      0
`define SARSQ_BIT_RC        15
`define SARSQ_TRIG_MANUAL   3'h0
`define SARSQ_TRIG_EXT      3'h1
`define SARSQ_TRIG_TMR3     3'h2
`define SARSQ_TRIG_TMR5     3'h4
`define SARSQ_TRIG_CHARGE   3'h6
`define SARSQ_TRIG_AUTO     3'h7
`define SARSQ_FMT_INT       2'h0
`define SARSQ_FMT_SINT      2'h1
`define SARSQ_FMT_FRAC      2'h2
`define SARSQ_FMT_SFRAC     2'h3
`define SARSQ_DIV_LIMIT     8'h3F
`define SARSQ_REF_EXTP      3'h1
`define SARSQ_REF_EXTN      3'h2
`define SARSQ_REF_BOTH      3'h3
`define SARSQ_CONV_TADS     5'h0C
`endif

// *** core/sarsq_tick.v ***
// conversion clock tick generator: period of (divider + 1) core cycles, divider capped at 3F; rc_select passes rc_tick through
`include "sarsq_map.vh"
module sarsq_tick #(
	parameter DIV_W = 8
) (
	input  wire             core_clk,
	input  wire             rst,
	input  wire             ce,
	input  wire             run,
	input  wire             rc_select,
	input  wire             rc_tick,
	input  wire [DIV_W-1:0] divider,
	output reg              tick
);
	reg [DIV_W-1:0] count_reg;
	wire [DIV_W-1:0] lim;
	assign lim = (divider > `SARSQ_DIV_LIMIT) ? `SARSQ_DIV_LIMIT : divider;
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			count_reg <= {DIV_W{1'b0}};
			tick <= 1'b0;
		end
		else if (ce)
		begin
			tick <= 1'b0;
			if (!run)
				count_reg <= {DIV_W{1'b0}};
			else if (rc_select)
				tick <= rc_tick;
			else if (count_reg >= lim)
			begin
				count_reg <= {DIV_W{1'b0}};
				tick <= 1'b1;
			end
			else
				count_reg <= count_reg + {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end
endmodule

// *** core/sarsq_format.v ***
// result formatter: presents a 10-bit code in one of four layouts
`include "sarsq_map.vh"
module sarsq_format (
	input  wire [1:0]  format,
	input  wire [9:0]  code,
	output reg  [15:0] word
);
	always @*
	begin
		case (format)
			`SARSQ_FMT_SFRAC: word = {~code[9], code[8:0], 6'h00};
			`SARSQ_FMT_FRAC:  word = {code, 6'h00};
			`SARSQ_FMT_SINT:  word = {{7{~code[9]}}, code[8:0]};
			default:          word = {6'h00, code};
		endcase
	end
endmodule

// *** sim/sarsq_conv_model.sv ***
// behavioural converter core: answers each start with one result after a delay
module sarsq_conv_model #(
	parameter DLY = 12
) (
	input  wire logic       core_clk,
	input  wire logic       conv_start,
	input  wire logic [9:0] code_in,
	output logic            conv_done,
	output logic [9:0]      conv_code
);
	timeunit 1ns;
	timeprecision 1ps;
	int         cnt = 0;
	logic [9:0] held = 10'h000;
	initial
	begin
		conv_done = 1'b0;
		conv_code = 10'h3FF;
	end
	// result lines toggle outside the done cycle so no stale value looks valid
	always @(posedge core_clk)
	begin
		conv_done <= 1'b0;
		conv_code <= ~conv_code;
		if (conv_start)
		begin
			cnt <= DLY;
			held <= code_in;
		end
		else if (cnt > 0)
			cnt <= cnt - 1;
		if (!conv_start && cnt == 1)
		begin
			conv_done <= 1'b1;
			conv_code <= held;
		end
	end
endmodule

// *** sim/sarsq_top_chk.sv ***
// port assertions for the converter sequencer
module sarsq_top_chk #(
	parameter CH_N = 16
) (
	input wire logic            core_clk,
	input wire logic            rst,
	input wire logic            ce,
	input wire logic [4:0]      reg_addr,
	input wire logic [15:0]     reg_wdata,
	input wire logic            reg_wr,
	input wire logic            reg_rd,
	input wire logic [15:0]     reg_rdata,
	input wire logic            device_idle,
	input wire logic            timer3_event,
	input wire logic            timer5_event,
	input wire logic            conv_done,
	input wire logic            converter_irq_flag,
	input wire logic            sample_enable,
	input wire logic            conv_start,
	input wire logic [2:0]      reference_select,
	input wire logic [CH_N-1:0] pin_analog_config,
	input wire logic            conv_clk_tick
);
	logic [15:0] sh1_reg;
	logic [15:0] sh3_reg;
	wire         on = sh1_reg[15];
	wire         halt = sh1_reg[13] && device_idle;
	wire         run = ce && on && !halt && sample_enable;
	wire         pcw = ce && reg_wr && reg_addr == 5'h04;
	// shadow copies of the first and third control words
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sh1_reg <= 16'h0000;
			sh3_reg <= 16'h0000;
		end
		else if (ce && reg_wr && reg_addr == 5'h00)
			sh1_reg <= reg_wdata;
		else if (ce && reg_wr && reg_addr == 5'h02)
			sh3_reg <= reg_wdata;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	unmapped_read_a:
		assert property (ce && reg_rd && !reg_addr[4] && reg_addr > 5'h06 |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	ref_fold_a: assert property (!reference_select[2])
		else $error("reference code 1xx driven");
	hold_at_start_a: assert property (conv_start |-> !sample_enable)
		else $error("sampling while converting");
	tmr3_start_a:
		assert property (run && sh1_reg[7:5] == 3'h2 && timer3_event |-> ##[1:3] conv_start)
		else $error("timer three event did not start conversion");
	tmr5_start_a:
		assert property (run && sh1_reg[7:5] == 3'h4 && timer5_event |-> ##[1:3] conv_start)
		else $error("timer five event did not start conversion");
	off_quiet_a:
		assert property (!on && !$past(on) |-> !sample_enable && !conv_start)
		else $error("activity while switched off");
	idle_halt_a: assert property (halt && $past(halt) && $past(halt, 2) |-> !conv_start)
		else $error("conversion started while halted in idle");
	irq_cause_a:
		assert property (converter_irq_flag |-> $past(conv_done) || $past(conv_done, 2) || $past(conv_done, 3))
		else $error("interrupt without completed conversion");
	pin_hold_a: assert property (!$past(pcw) && !$past(pcw, 2) |-> $stable(pin_analog_config))
		else $error("pin configuration changed without a write");
	tick_space_a:
		assert property (conv_clk_tick && on && !sh3_reg[15] && sh3_reg[7:0] == 8'h01 |=> !conv_clk_tick)
		else $error("conversion tick faster than divider allows");
endmodule
bind sarsq_top sarsq_top_chk #(.CH_N(CH_N)) u_sarsq_top_chk (
	.core_clk(core_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .device_idle(device_idle),
	.timer3_event(timer3_event), .timer5_event(timer5_event), .conv_done(conv_done),
	.converter_irq_flag(converter_irq_flag), .sample_enable(sample_enable), .conv_start(conv_start),
	.reference_select(reference_select), .pin_analog_config(pin_analog_config),
	.conv_clk_tick(conv_clk_tick)
);

// *** sim/sarsq_top_tb.sv ***
// self-checking bench for the converter sequencer
module sarsq_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        device_idle = 1'b0;
	logic [3:0]  ev = 4'h0;
	logic [9:0]  code_in = 10'h2C5;
	logic [15:0] reg_rdata, pin_cfg;
	logic [9:0]  conv_code;
	logic [4:0]  pos_sel;
	logic [2:0]  ref_sel;
	logic        conv_done, conv_start, irq, sample_enable, neg_alt, tick;
	int          n_errors = 0, n_checks = 0, cyc = 0, n_starts = 0, n_irq = 0;
	sarsq_top u_sarsq_top (
		.core_clk(core_clk), .rst(rst), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .device_idle(device_idle),
		.rc_tick(1'b0), .timer3_event(ev[1]), .timer5_event(ev[2]), .charge_time_unit_event(ev[3]),
		.external_irq_zero(ev[0]), .conv_done(conv_done), .conv_code(conv_code),
		.converter_irq_flag(irq), .sample_enable(sample_enable), .conv_start(conv_start),
		.positive_select(pos_sel), .negative_alt(neg_alt), .reference_select(ref_sel),
		.pin_analog_config(pin_cfg), .conv_clk_tick(tick)
	);
	sarsq_conv_model u_sarsq_conv_model (
		.core_clk(core_clk), .conv_start(conv_start), .code_in(code_in), .conv_done(conv_done),
		.conv_code(conv_code)
	);
	always #12.5 core_clk = ~core_clk;
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cyc++;
		n_starts += conv_start;
		n_irq += irq;
		if (cyc == 20000)
		begin
			n_errors++;
			end_of_test();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk) #1;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic wait_start(input int lim, input logic exp);
		#1;
		for (int i = 0; i < lim && !conv_start; i++)
			@(posedge core_clk) #1;
		check(conv_start, exp);
	endtask
	function automatic logic [15:0] fmt(input int f, input logic [9:0] c);
		case (f)
			0: return {6'h00, c};
			1: return {{7{~c[9]}}, c[8:0]};
			3: return {~c[9], c[8:0], 6'h00};
			default: return {c, 6'h00};
		endcase
	endfunction
	// reset values, writable masks, unmapped place, reference folding
	task automatic t_regs();
		logic [15:0] d;
		logic [4:0]  ta [6] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07};
		logic [15:0] tw [6] = '{16'hFFFF, 16'hFF3F, 16'hFFFF, 16'h5AA5, 16'hA55A, 16'hFFFF};
		logic [15:0] te [6] = '{16'hE43F, 16'h9F3F, 16'h1F1F, 16'h5AA5, 16'hA55A, 16'h0000};
		for (int a = 0; a < 6; a++)
		begin
			rd(ta[a], d);
			check(d, 16'h0000);
			wr(ta[a], tw[a]);
			rd(ta[a], d);
			check(d, te[a]);
		end
		check(pin_cfg, 16'h5AA5);
		for (int v = 7; v >= 0; v--)
		begin
			wr(5'h01, {v[2:0], 13'h0000});
			idle(2);
			check(ref_sel, v[2] ? 3'h0 : v[2:0]);
		end
	endtask
	// manual sampling in each output format, status bit, switch-off loss
	task automatic t_formats();
		logic [15:0] d;
		wr(5'h02, 16'h0000);
		for (int f = 0; f < 4; f++)
		begin
			wr(5'h00, 16'h8002 | 16'(f << 8));
			idle(4);
			check(sample_enable, 1'b1);
			wr(5'h00, 16'h8000 | 16'(f << 8));
			wait_start(8, 1'b1);
			idle(30);
			rd(5'h00, d);
			check(d, 16'h8001 | 16'(f << 8));
			rd(5'h10, d);
			check(d, fmt(f, code_in));
			wr(5'h00, 16'h0000);
			rd(5'h10, d);
			check(d, 16'h0000);
		end
	endtask
	// each event source, reserved codes never start
	task automatic t_triggers();
		logic [2:0] tr [6] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h3, 3'h5};
		logic [3:0] em [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hF, 4'hF};
		for (int i = 0; i < 6; i++)
		begin
			wr(5'h00, 16'h8002 | {8'h00, tr[i], 5'h00});
			idle(4);
			wait_start(20, 1'b0);
			@(posedge core_clk);
			ev <= em[i];
			wait_start(12, i < 4);
			@(posedge core_clk);
			ev <= 4'h0;
			wr(5'h00, 16'h0000);
			idle(30);
		end
	endtask
	// auto sampling, alternate inputs, interrupt rate, idle stop
	task automatic t_auto();
		int s;
		wr(5'h03, 16'h0503);
		wr(5'h01, 16'h0005);
		wr(5'h02, 16'h0201);
		n_irq = 0;
		wr(5'h00, 16'h80E4);
		for (int i = 0; i < 4; i++)
		begin
			wait_start(200, 1'b1);
			check(pos_sel, i[0] ? 5'h05 : 5'h03);
			idle(1);
		end
		idle(25);
		check(16'(n_irq), 16'h0002);
		wr(5'h00, 16'hA0E4);
		@(posedge core_clk);
		device_idle <= 1'b1;
		idle(40);
		s = n_starts;
		idle(80);
		check(16'(n_starts - s), 16'h0000);
		@(posedge core_clk);
		device_idle <= 1'b0;
		wait_start(200, 1'b1);
		wr(5'h00, 16'h0000);
	endtask
	initial
	begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		t_regs();
		t_formats();
		t_triggers();
		t_auto();
		end_of_test();
	end
endmodule
